/* File: ies_pkg.sv */
/*
  package for the internal error severity and inject register bank:
  register offsets, field positions, reset values and bus carrier structs.
  assumes a 32-bit AXI4-Lite register bus with 12 significant address bits.
*/
package ies_pkg;

  // register byte offsets
  localparam logic [11:0] IES_OFS_STATUS = 12'h480;
  localparam logic [11:0] IES_OFS_MASK = 12'h484;
  localparam logic [11:0] IES_OFS_SEVERITY = 12'h48c;
  localparam logic [11:0] IES_OFS_INJECT = 12'h490;
  localparam logic [11:0] IES_OFS_IRQ_STATUS = 12'h494;
  localparam logic [11:0] IES_OFS_IRQ_MASK = 12'h498;

  // address and data widths
  localparam int IES_AW = 12;
  localparam int IES_DW = 32;
  localparam int IES_NERR = 19;

  // internal error field positions
  localparam int IES_BIT_ING_POSTED_TO = 0;
  localparam int IES_BIT_ING_NONPOSTED_TO = 1;
  localparam int IES_BIT_ING_COMPL_TO = 2;
  localparam int IES_BIT_RESERVED = 3;
  localparam int IES_BIT_EGR_POSTED_TO = 4;
  localparam int IES_BIT_EGR_NONPOSTED_TO = 5;
  localparam int IES_BIT_EGR_COMPL_TO = 6;
  localparam int IES_BIT_ING_DATA_SINGLE = 7;
  localparam int IES_BIT_ING_DATA_DOUBLE = 8;
  localparam int IES_BIT_ING_CTL_SINGLE = 9;
  localparam int IES_BIT_ING_CTL_DOUBLE = 10;
  localparam int IES_BIT_EGR_DATA_SINGLE = 11;
  localparam int IES_BIT_EGR_DATA_DOUBLE = 12;
  localparam int IES_BIT_EGR_CTL_SINGLE = 13;
  localparam int IES_BIT_EGR_CTL_DOUBLE = 14;
  localparam int IES_BIT_E2E_PARITY = 15;
  localparam int IES_BIT_UNRELIABLE_LINK = 16;
  localparam int IES_BIT_REPLAY_CTL_SINGLE = 17;
  localparam int IES_BIT_REPLAY_CTL_DOUBLE = 18;

  // interrupt status field positions
  localparam int IES_IRQ_BIT_UNCOR = 0;
  localparam int IES_IRQ_BIT_COR = 1;
  localparam int IES_NIRQ = 2;

  // implemented bits and reset values
  localparam logic [IES_NERR-1:0] IES_ERR_DEFINED = 19'h7fff7;
  localparam logic [IES_NERR-1:0] IES_SEVERITY_RESET = 19'h4d511;
  localparam logic [IES_NERR-1:0] IES_MASK_RESET = 19'h00000;
  localparam logic [IES_NERR-1:0] IES_STATUS_RESET = 19'h00000;
  localparam logic [IES_DW-1:0] IES_INJECT_RESET = 32'h00000000;
  localparam logic [IES_NIRQ-1:0] IES_IRQ_RESET = 2'h0;

  // axi response codes
  localparam logic [1:0] IES_RESP_OKAY = 2'h0;
  localparam logic [1:0] IES_RESP_DECERR = 2'h3;

  // master to slave signals
  typedef struct packed {
    logic [IES_AW-1:0] awaddr;
    logic awvalid;
    logic [IES_DW-1:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [IES_AW-1:0] araddr;
    logic arvalid;
    logic rready;
  } ies_axil_req_s;

  // slave to master signals
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [IES_DW-1:0] rdata;
    logic [1:0] rresp;
  } ies_axil_rsp_s;

endpackage

/* File: ies_sticky.sv */
/*
  vector of sticky flags: set by hardware, cleared by a one-cycle clear vector.
  assumes set and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
module ies_sticky #(
  parameter int W = 1,
  parameter logic [W-1:0] KEEP = '1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // flag control
  input wire logic [W-1:0] set_in,
  input wire logic [W-1:0] clr_in,
  // flag state
  output logic [W-1:0] flag_out
);

  // a set in the clearing cycle wins over the clear
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flag_out <= '0;
    end else begin
      flag_out <= ((flag_out & ~clr_in) | set_in) & KEEP;
    end
  end

endmodule

/* File: ies_regs.sv */
/*
  internal error severity, inject, status and mask registers of one switch
  port, with an axi4-lite slave, correctable and uncorrectable report outputs
  and an interrupt.
  assumes error detect pulses come from core logic on REF_CLK_IN.
*/
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
// Behaviour
// - set unmasked error with severity one: uncorrectable
// - set unmasked error with severity zero: correctable
// - severity bit 12 read-write, default one
// - severity bits 13, 14 default zero, one
// - severity bit 15 defaults to one
// - severity bit 16 defaults to zero
// - severity bits 17, 18 default zero, one
// - inject one sets status bit; zero nothing
// - inject bits always read back zero
// - inject bits 0-2 ingress timeouts, 3 reserved
// - inject bits 4-6 egress timeouts
// - inject bits 7-10 ingress memory errors
// - inject bits 11-14 egress memory errors
// - inject bits 15-18 parity, link, replay errors
module ies_regs (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic NRST_IN,
  // register bus
  input wire ies_pkg::ies_axil_req_s AXIL_REQ_IN,
  output ies_pkg::ies_axil_rsp_s AXIL_RSP_OUT,
  // natural error detect pulses, one per internal error type
  input wire logic [ies_pkg::IES_NERR-1:0] ERR_DETECT_IN,
  // error reporting
  output logic UNCOR_ERR_OUT,
  output logic COR_ERR_OUT,
  output logic IRQ_OUT
);

  import ies_pkg::*;

  logic [IES_NERR-1:0] severity;
  logic [IES_NERR-1:0] err_mask;
  logic [IES_NERR-1:0] err_status;
  logic [IES_NIRQ-1:0] irq_mask;
  logic [IES_NIRQ-1:0] irq_status;
  logic [IES_AW-1:0] aw_addr;
  logic [IES_DW-1:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [IES_DW-1:0] wr_bits;
  logic wr_hit;
  logic [IES_DW-1:0] rd_data;
  logic rd_hit;
  logic [IES_NERR-1:0] inject_set;
  logic [IES_NERR-1:0] status_clr;
  logic [IES_NERR-1:0] live;
  logic [IES_NIRQ-1:0] irq_set;
  logic [IES_NIRQ-1:0] irq_clr;
  logic sev_written;
  logic aw_ready;
  logic w_ready;
  logic b_valid;
  logic [1:0] b_resp;
  logic ar_ready;
  logic r_valid;
  logic [IES_DW-1:0] r_data;
  logic [1:0] r_resp;
  logic [IES_DW-1:0] strb_bits;

  // response fields gathered into the carrier, each straight from a flop
  assign AXIL_RSP_OUT = '{awready: aw_ready, wready: w_ready, bvalid: b_valid, bresp: b_resp,
    arready: ar_ready, rvalid: r_valid, rdata: r_data, rresp: r_resp};

  // write address and data accepted in either order
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      aw_ready <= 1'b1;
      aw_addr <= '0;
    end else if (AXIL_REQ_IN.awvalid && aw_ready) begin
      aw_ready <= 1'b0;
      aw_addr <= AXIL_REQ_IN.awaddr;
    end else if (b_valid && AXIL_REQ_IN.bready) begin
      aw_ready <= 1'b1;
    end
  end

  // write data capture
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      w_ready <= 1'b1;
      w_data <= '0;
      w_strb <= '0;
    end else if (AXIL_REQ_IN.wvalid && w_ready) begin
      w_ready <= 1'b0;
      w_data <= AXIL_REQ_IN.wdata;
      w_strb <= AXIL_REQ_IN.wstrb;
    end else if (b_valid && AXIL_REQ_IN.bready) begin
      w_ready <= 1'b1;
    end
  end

  // the write takes effect once, the cycle after both halves are held
  assign wr_fire = !aw_ready && !w_ready && !b_valid;
  assign strb_bits = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign wr_bits = w_data & strb_bits;

  // write address decode
  always_comb begin
    unique case (aw_addr)
      IES_OFS_STATUS, IES_OFS_MASK, IES_OFS_SEVERITY, IES_OFS_INJECT, IES_OFS_IRQ_STATUS,
      IES_OFS_IRQ_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // write response
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      b_valid <= 1'b0;
      b_resp <= IES_RESP_OKAY;
    end else if (wr_fire) begin
      b_valid <= 1'b1;
      b_resp <= wr_hit ? IES_RESP_OKAY : IES_RESP_DECERR;
    end else if (AXIL_REQ_IN.bready) begin
      b_valid <= 1'b0;
    end
  end

  // severity register, software retained, reserved bits dropped
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      severity <= IES_SEVERITY_RESET;
    end else if (wr_fire && aw_addr == IES_OFS_SEVERITY) begin
      // strobed bytes take the written value, zeros included
      severity <= ((severity & ~strb_bits[IES_NERR-1:0]) | (w_data[IES_NERR-1:0] & strb_bits[IES_NERR-1:0]))
        & IES_ERR_DEFINED;
    end
  end

  // error mask register
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      err_mask <= IES_MASK_RESET;
    end else if (wr_fire && aw_addr == IES_OFS_MASK) begin
      err_mask <= wr_bits[IES_NERR-1:0] & IES_ERR_DEFINED;
    end
  end

  // interrupt mask register
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      irq_mask <= IES_IRQ_RESET;
    end else if (wr_fire && aw_addr == IES_OFS_IRQ_MASK) begin
      irq_mask <= wr_bits[IES_NIRQ-1:0];
    end
  end

  // inject bits map one to one onto status bits and are never stored
  assign inject_set = (wr_fire && aw_addr == IES_OFS_INJECT) ?
    (wr_bits[IES_NERR-1:0] & IES_ERR_DEFINED) : '0;
  assign status_clr = (wr_fire && aw_addr == IES_OFS_STATUS) ? wr_bits[IES_NERR-1:0] : '0;

  // error status: natural and injected errors share one path
  ies_sticky #(
    .W(IES_NERR),
    .KEEP(IES_ERR_DEFINED)
  ) u_err_status (
    .clk_in(REF_CLK_IN),
    .nrst_in(NRST_IN),
    .set_in(ERR_DETECT_IN | inject_set),
    .clr_in(status_clr),
    .flag_out(err_status)
  );

  // unmasked pending errors, split by severity
  assign live = err_status & ~err_mask;

  // report outputs
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      UNCOR_ERR_OUT <= 1'b0;
      COR_ERR_OUT <= 1'b0;
    end else begin
      UNCOR_ERR_OUT <= |(live & severity);
      COR_ERR_OUT <= |(live & ~severity);
    end
  end

  // interrupt events: a report output that starts
  assign irq_set[IES_IRQ_BIT_UNCOR] = |(live & severity) && !UNCOR_ERR_OUT;
  assign irq_set[IES_IRQ_BIT_COR] = |(live & ~severity) && !COR_ERR_OUT;
  assign irq_clr = (wr_fire && aw_addr == IES_OFS_IRQ_STATUS) ? wr_bits[IES_NIRQ-1:0] : '0;

  // interrupt status flags
  ies_sticky #(
    .W(IES_NIRQ),
    .KEEP('1)
  ) u_irq_status (
    .clk_in(REF_CLK_IN),
    .nrst_in(NRST_IN),
    .set_in(irq_set),
    .clr_in(irq_clr),
    .flag_out(irq_status)
  );

  // interrupt line
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= |(irq_status & irq_mask);
    end
  end

  // read decode, upper bits zero
  always_comb begin
    rd_data = '0;
    rd_hit = 1'b1;
    unique case (AXIL_REQ_IN.araddr)
      IES_OFS_STATUS: rd_data[IES_NERR-1:0] = err_status;
      IES_OFS_MASK: rd_data[IES_NERR-1:0] = err_mask;
      IES_OFS_SEVERITY: rd_data[IES_NERR-1:0] = severity;
      IES_OFS_INJECT: rd_data = IES_INJECT_RESET;
      IES_OFS_IRQ_STATUS: rd_data[IES_NIRQ-1:0] = irq_status;
      IES_OFS_IRQ_MASK: rd_data[IES_NIRQ-1:0] = irq_mask;
      default: rd_hit = 1'b0;
    endcase
  end

  // read channel: data follows the address one cycle later
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ar_ready <= 1'b1;
      r_valid <= 1'b0;
      r_data <= '0;
      r_resp <= IES_RESP_OKAY;
    end else if (AXIL_REQ_IN.arvalid && ar_ready) begin
      ar_ready <= 1'b0;
      r_valid <= 1'b1;
      r_data <= rd_data;
      r_resp <= rd_hit ? IES_RESP_OKAY : IES_RESP_DECERR;
    end else if (r_valid && AXIL_REQ_IN.rready) begin
      ar_ready <= 1'b1;
      r_valid <= 1'b0;
    end
  end

  // helper: severity untouched since reset
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      sev_written <= 1'b0;
    end else if (wr_fire && aw_addr == IES_OFS_SEVERITY) begin
      sev_written <= 1'b1;
    end
  end

  // an unmasked uncorrectable error shows on the next edge
  property p_uncor_report;
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
      |(err_status & ~err_mask & severity) |=> UNCOR_ERR_OUT;
  endproperty
  a_uncor_report: assert property (p_uncor_report) else $error("uncorrectable report missing");

  // the correctable report never shows without a cause on the edge before
  property p_cor_report;
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
      COR_ERR_OUT |-> $past(|(err_status & ~err_mask & ~severity));
  endproperty
  a_cor_report: assert property (p_cor_report) else $error("correctable report without cause");

  // an unmasked correctable error raises the correctable report next edge
  property p_cor_set;
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
      |(err_status & ~err_mask & ~severity) |=> COR_ERR_OUT;
  endproperty
  a_cor_set: assert property (p_cor_set) else $error("correctable report missing");

  // the uncorrectable report never shows without a cause
  property p_uncor_cause;
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
      UNCOR_ERR_OUT |-> $past(|(err_status & ~err_mask & severity));
  endproperty
  a_uncor_cause: assert property (p_uncor_cause) else $error("uncorrectable report without cause");

  // severity holds its reset layout until software writes it
  property p_sev_default;
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
      !sev_written |-> severity == IES_SEVERITY_RESET;
  endproperty
  a_sev_default: assert property (p_sev_default) else $error("severity default wrong");

  // severity bit 12 follows a full write of it
  property p_sev_rw;
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
      (wr_fire && aw_addr == IES_OFS_SEVERITY && w_strb[1])
        |=> severity[IES_BIT_EGR_DATA_DOUBLE] == $past(w_data[IES_BIT_EGR_DATA_DOUBLE]);
  endproperty
  a_sev_rw: assert property (p_sev_rw) else $error("severity bit not writable");

  // reserved bits never read as one
  property p_reserved_zero;
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
      AXIL_RSP_OUT.rvalid |-> AXIL_RSP_OUT.rdata[31:19] == 13'h0 && !severity[IES_BIT_RESERVED];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  // each injected one lands in the status one edge later
  property p_inject_sets;
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
      (wr_fire && aw_addr == IES_OFS_INJECT)
        |=> (err_status & $past(wr_bits[IES_NERR-1:0] & IES_ERR_DEFINED))
          == $past(wr_bits[IES_NERR-1:0] & IES_ERR_DEFINED);
  endproperty
  a_inject_sets: assert property (p_inject_sets) else $error("inject did not set status");

  // inject reads back zero
  property p_inject_reads_zero;
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
      (AXIL_REQ_IN.arvalid && AXIL_RSP_OUT.arready && AXIL_REQ_IN.araddr == IES_OFS_INJECT)
        |=> AXIL_RSP_OUT.rvalid && AXIL_RSP_OUT.rdata == 32'h00000000;
  endproperty
  a_inject_reads_zero: assert property (p_inject_reads_zero) else $error("inject read not zero");

  // the reserved status position stays clear
  property p_status_bit3;
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
      !err_status[IES_BIT_RESERVED];
  endproperty
  a_status_bit3: assert property (p_status_bit3) else $error("reserved status bit set");

  // injected unmasked uncorrectable error reaches the report within two edges
  property p_inject_reported;
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
      (wr_fire && aw_addr == IES_OFS_INJECT && |(wr_bits[IES_NERR-1:0] & ~err_mask & severity & IES_ERR_DEFINED)
        && !(wr_fire && aw_addr == IES_OFS_MASK)) |=> ##1 UNCOR_ERR_OUT || $past(status_clr != '0);
  endproperty
  a_inject_reported: assert property (p_inject_reported) else $error("injected error not reported");

  // write response stands until taken
  property p_bvalid_hold;
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
      (AXIL_RSP_OUT.bvalid && !AXIL_REQ_IN.bready) |=> AXIL_RSP_OUT.bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");

  // an accepted read address is answered on the next edge
  property p_read_answer;
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
      (AXIL_REQ_IN.arvalid && AXIL_RSP_OUT.arready) |=> AXIL_RSP_OUT.rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");

  // an enabled pending interrupt flag drives the line next edge
  property p_irq_line;
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
      |(irq_status & irq_mask) |=> IRQ_OUT;
  endproperty
  a_irq_line: assert property (p_irq_line) else $error("interrupt line missing");

endmodule

/* File: tb_top.sv */
/*
  self-checking bench for the internal error severity and inject register bank.
  assumes ies_pkg and ies_regs are compiled first and one 50 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin fail_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

module tb_top;
  import ies_pkg::*;

  // design connections
  logic ref_clk = 1'b0;
  logic nrst;
  ies_axil_req_s req;
  ies_axil_rsp_s rsp;
  logic [IES_NERR-1:0] err_det;
  logic uncor;
  logic cor;
  logic irq;
  // bench state
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [1:0] rs;
  localparam logic [31:0] SEV_DEF = 32'h0004d511;
  localparam logic [31:0] DEFINED = 32'h0007fff7;

  ies_regs i_ies_regs (.REF_CLK_IN(ref_clk), .NRST_IN(nrst), .AXIL_REQ_IN(req), .AXIL_RSP_OUT(rsp),
    .ERR_DETECT_IN(err_det), .UNCOR_ERR_OUT(uncor), .COR_ERR_OUT(cor), .IRQ_OUT(irq));

  // free running clock
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  // verdict and end of run
  task automatic tally_and_finish();
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang watchdog, far above the well under a thousand cycles needed
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // one write, address and data offered together, response into rs
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    bit done;
    done = 0;
    @(posedge ref_clk);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!done) begin
      @(posedge ref_clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        rs = rsp.bresp;
        req.bready <= 1'b0;
        done = 1;
      end
    end
  endtask

  // one read, data into rd and response into rs
  task automatic axi_rd(input logic [11:0] a);
    bit done;
    done = 0;
    @(posedge ref_clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    while (!done) begin
      @(posedge ref_clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) begin
        rd = rsp.rdata;
        rs = rsp.rresp;
        req.rready <= 1'b0;
        done = 1;
      end
    end
  endtask

  // let status, reports and interrupt ripple through
  task automatic settle();
    repeat (4) @(posedge ref_clk);
  endtask

  // reset values of severity and inject, quiet report outputs
  task automatic t_reset();
    axi_rd(IES_OFS_SEVERITY);
    `CHK("severity reset", SEV_DEF, rd)
    axi_rd(IES_OFS_INJECT);
    `CHK("inject reset", 32'h0, rd)
    `CHK("uncor idle", 1'b0, uncor)
    `CHK("cor idle", 1'b0, cor)
  endtask

  // severity is writable, upper bits stay zero, flipping it flips the class
  task automatic t_severity();
    axi_wr(IES_OFS_SEVERITY, 32'hffffffff);
    axi_rd(IES_OFS_SEVERITY);
    `CHK("severity all ones", DEFINED, rd)
    axi_wr(IES_OFS_INJECT, 32'h00010000);
    settle();
    `CHK("link err uncor", 1'b1, uncor)
    axi_wr(IES_OFS_STATUS, 32'hffffffff);
    axi_wr(IES_OFS_SEVERITY, 32'h0);
    axi_wr(IES_OFS_INJECT, 32'h00001000);
    settle();
    `CHK("egress data double cor", 1'b1, cor)
    `CHK("egress data double uncor", 1'b0, uncor)
    axi_wr(IES_OFS_STATUS, 32'hffffffff);
    axi_wr(IES_OFS_SEVERITY, SEV_DEF);
  endtask

  // every inject bit alone: sets its status bit except reserved bit 3, reads zero, reports by default severity
  task automatic t_inject();
    logic [31:0] b;
    for (int i = 0; i < 19; i++) begin
      b = 32'h1 << i;
      axi_wr(IES_OFS_INJECT, b);
      axi_wr(IES_OFS_INJECT, 32'h0);
      settle();
      axi_rd(IES_OFS_STATUS);
      `CHK("status after inject", DEFINED & b, rd)
      `CHK("uncor after inject", SEV_DEF[i] & DEFINED[i], uncor)
      `CHK("cor after inject", ~SEV_DEF[i] & DEFINED[i], cor)
      axi_rd(IES_OFS_INJECT);
      `CHK("inject readback", 32'h0, rd)
      axi_wr(IES_OFS_STATUS, b);
      settle();
      `CHK("uncor cleared", 1'b0, uncor)
      `CHK("cor cleared", 1'b0, cor)
    end
  endtask

  // mask hides the report but not the status; natural error treated alike
  task automatic t_mask();
    axi_wr(IES_OFS_MASK, 32'h00008000);
    axi_wr(IES_OFS_INJECT, 32'h00008000);
    settle();
    axi_rd(IES_OFS_STATUS);
    `CHK("masked status", 32'h00008000, rd)
    `CHK("masked uncor", 1'b0, uncor)
    axi_wr(IES_OFS_MASK, 32'h0);
    settle();
    `CHK("unmasked parity uncor", 1'b1, uncor)
    axi_wr(IES_OFS_STATUS, 32'h00008000);
    @(posedge ref_clk);
    err_det <= 19'h02000;
    @(posedge ref_clk);
    err_det <= 19'h0;
    settle();
    `CHK("natural ctl single cor", 1'b1, cor)
    axi_wr(IES_OFS_STATUS, 32'h00002000);
  endtask

  // interrupt raised, cleared, then held off by its mask
  task automatic t_irq();
    axi_wr(IES_OFS_IRQ_STATUS, 32'h3);
    axi_wr(IES_OFS_IRQ_MASK, 32'h1);
    settle();
    `CHK("irq idle", 1'b0, irq)
    axi_wr(IES_OFS_INJECT, 32'h00040000);
    settle();
    `CHK("irq on uncor", 1'b1, irq)
    axi_rd(IES_OFS_IRQ_STATUS);
    `CHK("irq status uncor", 32'h1, rd)
    axi_wr(IES_OFS_STATUS, 32'h00040000);
    axi_wr(IES_OFS_IRQ_STATUS, 32'h1);
    settle();
    `CHK("irq cleared", 1'b0, irq)
    axi_wr(IES_OFS_IRQ_MASK, 32'h0);
    axi_wr(IES_OFS_INJECT, 32'h00020000);
    settle();
    `CHK("irq masked", 1'b0, irq)
    axi_rd(IES_OFS_IRQ_STATUS);
    `CHK("irq status cor", 32'h2, rd)
    axi_wr(IES_OFS_STATUS, 32'hffffffff);
    axi_wr(IES_OFS_IRQ_STATUS, 32'h3);
  endtask

  // unmapped address refused, all-ones inject touches defined bits only
  task automatic t_edges();
    axi_wr(12'h4a0, 32'hffffffff);
    `CHK("unmapped write resp", IES_RESP_DECERR, rs)
    axi_rd(12'h4a0);
    `CHK("unmapped read resp", IES_RESP_DECERR, rs)
    `CHK("unmapped read data", 32'h0, rd)
    axi_wr(IES_OFS_INJECT, 32'hffffffff);
    `CHK("inject write resp", IES_RESP_OKAY, rs)
    axi_rd(IES_OFS_STATUS);
    `CHK("status all injected", DEFINED, rd)
    axi_wr(IES_OFS_STATUS, 32'hffffffff);
    axi_rd(IES_OFS_STATUS);
    `CHK("status cleared", 32'h0, rd)
  endtask

  // reset then scenarios in turn
  initial begin
    nrst = 1'b0;
    req = '0;
    err_det = '0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_severity();
    t_inject();
    t_mask();
    t_irq();
    t_edges();
    tally_and_finish();
  end
endmodule
